// >>> design/bcl_pkg.sv
// Package: widths, reset values and carrier structs of the buffered capture latch
package bcl_pkg;
  localparam int          TIMER_WIDTH  = 16;
  localparam int          SYNC_STAGES  = 3;
  localparam logic [15:0] ZERO_COUNT   = 16'h0000;
  localparam logic [15:0] VALUE_RESET  = 16'h0000;
  localparam logic [1:0]  EDGE_NONE    = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_FALL    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;

  // Latch event sources from the modulus counter side
  typedef struct packed {
    logic        count_zero;
    logic        count_write;
    logic [15:0] count_wdata;
    logic        force_latch_bit;
  } bcl_latch_src_type;

  // Software read strobes for the two registers
  typedef struct packed {
    logic capture_read;
    logic holding_read;
  } bcl_read_type;

  // Channel configuration levels
  typedef struct packed {
    logic       latch_mode_select;
    logic       no_overwrite_bit;
    logic [1:0] edge_select;
  } bcl_cfg_type;
endpackage : bcl_pkg

// >>> design/bcl_channel.sv
// Buffered input-capture channel in latch mode with capture and holding registers
`timescale 1ns/1ps
// Contract
// [RULE_01] The channel behaves in latch mode whenever the latch mode select bit is 1.
// [RULE_02] Each valid input pin transition stores the main timer value into the capture register.
// [RULE_03] Each modulus counter reach of zero copies the capture register into the holding register.
// [RULE_04] A write of 0x0000 to the modulus counter also copies capture into holding.
// [RULE_05] A write to the force latch bit also copies capture into holding.
// [RULE_06] With no-overwrite clear, every capture replaces the capture register.
// [RULE_07] With no-overwrite clear, every latch event replaces the holding register.
// [RULE_08] With no-overwrite set, a capture is stored only if the capture register is empty.
// [RULE_09] The capture register becomes empty when read or when latched into holding.
// [RULE_10] The holding register becomes empty only when read.
// [RULE_11] With no-overwrite set, a latch updates holding only if holding is empty.
module bcl_channel
#(
  parameter int TIMER_WIDTH = bcl_pkg::TIMER_WIDTH
)
(
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            capture_pin,
  input  wire logic [TIMER_WIDTH-1:0]          main_timer,
  input  wire bcl_pkg::bcl_cfg_type            cfg,
  input  wire bcl_pkg::bcl_latch_src_type      latch_src,
  input  wire bcl_pkg::bcl_read_type           rd,
  output logic [TIMER_WIDTH-1:0]               capture_value,
  output logic [TIMER_WIDTH-1:0]               holding_value,
  output logic                                 capture_full,
  output logic                                 holding_full,
  output logic                                 capture_event,
  output logic                                 latch_event
);

  // Synchroniser stages, edge history and qualified edges
  logic [bcl_pkg::SYNC_STAGES-1:0] pin_sync;
  logic                            pin_state;
  logic                            pin_settled;
  logic                            pin_rise;
  logic                            pin_fall;
  logic                            valid_edge;

  // Latch sources and acceptance
  logic                            count_zero_hit;
  logic                            zero_write_hit;
  logic                            force_hit;
  logic                            latch_req;
  logic                            capture_blocked;
  logic                            holding_blocked;
  logic                            do_capture;
  logic                            do_latch;

  // Emptying conditions of the two registers
  logic                            capture_empties;
  logic                            holding_empties;

  // Three-stage shift of the asynchronous pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_sync <= '0;
    end
    else
    begin
      pin_sync <= {pin_sync[bcl_pkg::SYNC_STAGES-2:0], capture_pin};
    end
  end

  // Accepted pin level, moved once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_state <= 1'b0;
    end
    else if (pin_settled)
    begin
      pin_state <= pin_sync[2];
    end
  end

  // Settled level differing from the accepted one is an edge
  assign pin_settled = (pin_sync[1] == pin_sync[2]);
  assign pin_rise    = pin_settled && pin_sync[2] && !pin_state;
  assign pin_fall    = pin_settled && !pin_sync[2] && pin_state;

  // Edge qualification against the selected polarity
  always_comb
  begin
    valid_edge = 1'b0;
    case (cfg.edge_select)
      bcl_pkg::EDGE_NONE:
      begin
        valid_edge = 1'b0;
      end
      bcl_pkg::EDGE_RISE:
      begin
        valid_edge = pin_rise;
      end
      bcl_pkg::EDGE_FALL:
      begin
        valid_edge = pin_fall;
      end
      bcl_pkg::EDGE_BOTH:
      begin
        valid_edge = pin_rise || pin_fall;
      end
      default:
      begin
        valid_edge = 1'b0;
      end
    endcase
  end

  // Latch sources: zero count, zero write, forced latch
  assign count_zero_hit = latch_src.count_zero; // RULE_03
  assign zero_write_hit = latch_src.count_write
                          && (latch_src.count_wdata == bcl_pkg::ZERO_COUNT); // RULE_04
  assign force_hit      = latch_src.force_latch_bit; // RULE_05

  // Latch events only count in latch mode
  assign latch_req = cfg.latch_mode_select && (count_zero_hit || zero_write_hit || force_hit); // RULE_01

  // Overwrite protection keeps unread values when no-overwrite is set
  assign capture_blocked = cfg.no_overwrite_bit && capture_full; // RULE_08
  assign holding_blocked = cfg.no_overwrite_bit && holding_full; // RULE_11
  assign do_capture      = valid_edge && !capture_blocked;       // RULE_06
  assign do_latch        = latch_req && !holding_blocked;        // RULE_07

  // Capture empties on a read or on a transfer to holding
  assign capture_empties = rd.capture_read || do_latch; // RULE_09

  // Holding empties only on a read
  assign holding_empties = rd.holding_read; // RULE_10

  // Capture register takes the main timer on an accepted edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      capture_value <= TIMER_WIDTH'(bcl_pkg::VALUE_RESET);
    end
    else if (do_capture)
    begin
      capture_value <= main_timer; // RULE_02
    end
  end

  // Capture full flag; a new capture wins over emptying
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      capture_full <= 1'b0;
    end
    else if (do_capture)
    begin
      capture_full <= 1'b1;
    end
    else if (capture_empties)
    begin
      capture_full <= 1'b0; // RULE_09
    end
  end

  // Holding register takes the old capture value on a latch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      holding_value <= TIMER_WIDTH'(bcl_pkg::VALUE_RESET);
    end
    else if (do_latch)
    begin
      holding_value <= capture_value; // RULE_03
    end
  end

  // Holding full flag; a latch wins over a read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      holding_full <= 1'b0;
    end
    else if (do_latch)
    begin
      holding_full <= 1'b1;
    end
    else if (holding_empties)
    begin
      holding_full <= 1'b0; // RULE_10
    end
  end

  // Capture pulse registered on the same edge as the store
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      capture_event <= 1'b0;
    end
    else
    begin
      capture_event <= do_capture;
    end
  end

  // Latch pulse registered on the same edge as the transfer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latch_event <= 1'b0;
    end
    else
    begin
      latch_event <= do_latch;
    end
  end

endmodule : bcl_channel

// >>> tb/bcl_partner.sv
// Modulus down-counter model pulsing on zero
`timescale 1ns/1ps
module bcl_partner (input logic clk, rst, load, output logic count_zero);
  logic [1:0] n;
  // Load three, count down, pulse once at zero
  always_ff @(posedge clk or posedge rst)
    if (rst) {n, count_zero} <= '0;
    else {n, count_zero} <= load ? 3'h6 : {n - 2'(n != 0), n == 2'h1};
endmodule : bcl_partner

// >>> tb/bcl_props.sv
// Checker on the latch channel ports
`timescale 1ns/1ps
module bcl_props (
  input logic clk, rst, capture_pin, capture_full, holding_full, capture_event, latch_event,
  input logic [15:0] main_timer, capture_value, holding_value,
  input bcl_pkg::bcl_cfg_type cfg, input bcl_pkg::bcl_latch_src_type latch_src, input bcl_pkg::bcl_read_type rd
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Qualified latch request and its acceptance
  wire nv = cfg.no_overwrite_bit;
  wire lq = cfg.latch_mode_select & (latch_src.count_zero | latch_src.force_latch_bit
    | latch_src.count_write & latch_src.count_wdata == 16'h0000);
  wire tk = lq & !(nv & holding_full);
  a_latch_copy: assert property
    (tk |=> holding_full && holding_value == $past(capture_value)) else $error("latch copy");
  a_hold_kept: assert property
    (lq && nv && holding_full |=> $stable(holding_value)) else $error("holding lost");
  a_mode_off: assert property
    (!cfg.latch_mode_select |=> $stable(holding_value)) else $error("latch when off");
  a_latch_pulse: assert property (tk |=> latch_event) else $error("latch pulse");
  a_cap_value: assert property
    (capture_event |-> capture_full && capture_value == $past(main_timer)) else $error("capture value");
  a_cap_kept: assert property
    (nv && capture_full && !rd.capture_read && !lq |=> $stable(capture_value)) else $error("capture lost");
  a_hold_empty: assert property ($fell(holding_full) |-> $past(rd.holding_read)) else $error("holding empty");
  a_cap_empty: assert property (tk |=> !capture_full || capture_event) else $error("capture full");
endmodule : bcl_props
bind bcl_channel bcl_props bcl_props_inst (.*);

// >>> tb/testbench.sv
// Self-checking bench for the latch channel
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, pin = 0, ld = 0, zero, hf, cf;
  logic [15:0] tmr = '0, cv, hv;
  bcl_pkg::bcl_cfg_type cfg = 4'hB;
  bcl_pkg::bcl_latch_src_type src = '0;
  bcl_pkg::bcl_read_type rd = '0;
  int mismatches = 0, n_checks = 0;
  bcl_channel bcl_channel_inst (.clk, .rst, .capture_pin(pin), .main_timer(tmr), .cfg, .latch_src({zero, src[17:0]}),
    .rd, .capture_value(cv), .holding_value(hv), .capture_full(cf), .holding_full(hf), .capture_event(), .latch_event());
  bcl_partner bcl_partner_inst (.clk, .rst, .load(ld), .count_zero(zero));
  initial forever #20 clk = ~clk;
  task automatic step(int n); repeat (n) @(posedge clk); #1; endtask : step
  task automatic end_sim;
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(string s, logic [15:0] g, e);
    n_checks++;
    if (g !== e) $display("FAIL %s expected %h seen %h", s, e, g);
    mismatches += (g !== e);
  endtask : chk
  task automatic cap(logic [15:0] v); tmr = v; pin = ~pin; step(6); endtask : cap
  task automatic lat(logic [18:0] s); src = s; step(1); src = '0; step(1); endtask : lat
  task automatic sc_latch;
    cap(16'h1111); cap(16'h2222); chk("capture", cv, 16'h2222);
    ld = 1; step(1); ld = 0; step(6); chk("holding", hv, 16'h2222);
    cap(16'h3333); lat(19'h20002); chk("holding", hv, 16'h2222);
    lat(19'h20000); chk("holding", hv, 16'h3333);
    cap(16'h4444); lat(19'h1); chk("holding", hv, 16'h4444);
  endtask : sc_latch
  task automatic sc_protect;
    cfg = 4'hF; cap(16'h5555); cap(16'h6666); chk("capture", cv, 16'h5555);
    lat(19'h1); chk("holding", hv, 16'h4444);
    rd = 2'h1; step(1); rd = '0; step(1); chk("holding_full", hf, 0);
    lat(19'h1); chk("holding", hv, 16'h5555);
    cfg = 4'h3; cap(16'h7777); lat(19'h1); chk("holding", hv, 16'h5555);
    chk("capture_full", cf, 1); rd = 2'h2; step(1); rd = '0; step(1); chk("capture_full", cf, 0);
  endtask : sc_protect
  initial
  begin
    step(5); rst = 0; sc_latch; sc_protect; end_sim;
  end
endmodule : testbench
